// ==== rtl/epr_slave.sv ====
// Two-wire EEPROM slave: reads, address counter, identification page
`include "epr_map.svh"

module epr_slave import epr_pkg::*; (
   input  wire logic mclk_in,
   input  wire logic sys_rst_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   output logic      id_locked_out,
   output logic      busy_out
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   epr_state_t  state_reg, state_next;
   epr_phase_t  phase_reg, phase_next;
   epr_bus_ev_t ev;
   logic        scl_d_reg, sda_d_reg;
   logic [3:0]  bitcnt_reg, bitcnt_next;
   logic [7:0]  shift_reg, shift_next;
   logic [7:0]  tx_reg, tx_next;
   logic        oe_reg, oe_next;
   logic        rd_reg, rd_next;
   logic        is_id_reg, is_id_next;
   logic        sel_reg, sel_next;
   logic        mack_reg, mack_next;
   logic        lock_pend_reg, lock_pend_next;
   logic [2:0]  blk_reg, blk_next;
   logic [10:0] cnt_reg, cnt_next;
   logic [3:0]  id_off_reg, id_off_next;
   logic [3:0]  cidx_reg, cidx_next;
   logic [15:0] vld_reg, vld_next;
   logic [7:0]  stage_reg [16];
   logic [7:0]  stage_next [16];
   logic        load_byte;
   logic        ack_ok;
   logic [11:0] raddr;
   logic [7:0]  rdata;
   logic        locked;

   // -------------------------------------------------------------
   // Line events
   // -------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_in;
         sda_d_reg <= sda_in;
      end
   end

   // Start and Stop are data edges with the clock held high
   always_comb begin
      ev.rise  = scl_in & ~scl_d_reg;
      ev.fall  = ~scl_in & scl_d_reg;
      ev.start = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
      ev.stop  = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
   end

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   // read address: identification page offset or main array counter
   assign raddr = is_id_reg ? {1'b1, 7'h00, id_off_reg} : {1'b0, cnt_reg};

   epr_mem u_mem (
      .clk_in      (mclk_in),
      .we_in       (state_reg == ST_COMMIT && vld_reg[cidx_reg]),
      .waddr_in    ({`EPR_ID_BASE, 3'h0, cidx_reg}),
      .wdata_in    (stage_reg[cidx_reg]),
      .lock_set_in (state_reg == ST_COMMIT && cidx_reg == `EPR_ID_LAST && lock_pend_reg),
      .raddr_in    (raddr),
      .rdata_out   (rdata),
      .locked_out  (locked)
   );

   // -------------------------------------------------------------
   // Protocol engine
   // -------------------------------------------------------------
   always_comb begin
      state_next     = state_reg;
      phase_next     = phase_reg;
      bitcnt_next    = bitcnt_reg;
      shift_next     = shift_reg;
      tx_next        = tx_reg;
      oe_next        = oe_reg;
      rd_next        = rd_reg;
      is_id_next     = is_id_reg;
      sel_next       = sel_reg;
      mack_next      = mack_reg;
      lock_pend_next = lock_pend_reg;
      blk_next       = blk_reg;
      cnt_next       = cnt_reg;
      id_off_next    = id_off_reg;
      cidx_next      = cidx_reg;
      vld_next       = vld_reg;
      stage_next     = stage_reg;
      load_byte      = 1'b0;
      ack_ok         = 1'b0;
      if (ev.start && state_reg != ST_COMMIT) begin
         state_next     = ST_RX;
         phase_next     = PH_DEV;
         bitcnt_next    = 4'h0;
         oe_next        = 1'b0;
         vld_next       = 16'h0000;
         lock_pend_next = 1'b0;
      end else if (ev.stop && state_reg != ST_COMMIT) begin
         oe_next   = 1'b0;
         cidx_next = 4'h0;
         state_next = (vld_reg != 16'h0000 || lock_pend_reg) ? ST_COMMIT : ST_IDLE;
      end else begin
         case (state_reg)
            ST_RX: begin
               if (ev.rise) begin
                  shift_next  = {shift_reg[6:0], sda_in};
                  bitcnt_next = bitcnt_reg + 4'h1;
               end
               if (ev.fall && bitcnt_reg == `EPR_BITS_BYTE) begin
                  bitcnt_next = 4'h0;
                  case (phase_reg)
                     PH_DEV: begin
                        ack_ok     = shift_reg[7:4] == `EPR_DEV_MAIN ||
                                     shift_reg[7:4] == `EPR_DEV_ID;
                        is_id_next = shift_reg[7:4] == `EPR_DEV_ID;
                        rd_next    = shift_reg[`EPR_RW_BIT];
                        if (shift_reg[7:4] == `EPR_DEV_MAIN) begin
                           blk_next = shift_reg[3:1];
                        end
                     end
                     PH_ADDR: begin
                        ack_ok = 1'b1;
                        if (is_id_reg) begin
                           sel_next    = shift_reg[`EPR_SEL_BIT];
                           id_off_next = shift_reg[3:0];
                        end else begin
                           cnt_next = {blk_reg, shift_reg};
                        end
                     end
                     PH_DATA: begin
                        if (!is_id_reg) begin
                           ack_ok   = 1'b1;
                           cnt_next = cnt_reg + 11'h001;
                        end else if (!locked) begin
                           ack_ok = 1'b1;
                           if (sel_reg) begin
                              lock_pend_next = lock_pend_reg | shift_reg[`EPR_LOCK_BIT];
                           end else begin
                              stage_next[id_off_reg] = shift_reg;
                              vld_next[id_off_reg]   = 1'b1;
                              id_off_next            = id_off_reg + 4'h1;
                           end
                        end
                     end
                     default: ack_ok = 1'b0;
                  endcase
                  oe_next    = ack_ok;
                  state_next = ack_ok ? ST_ACK : ST_IDLE;
               end
            end
            ST_ACK: begin
               if (ev.fall) begin
                  if (phase_reg == PH_DEV && rd_reg) begin
                     load_byte = 1'b1;
                  end else begin
                     oe_next    = 1'b0;
                     state_next = ST_RX;
                     phase_next = (phase_reg == PH_DEV) ? PH_ADDR : PH_DATA;
                  end
               end
            end
            ST_TX: begin
               if (ev.fall) begin
                  if (bitcnt_reg == `EPR_BITS_BYTE) begin
                     oe_next    = 1'b0;
                     state_next = ST_MACK;
                  end else begin
                     oe_next     = ~tx_reg[6];
                     tx_next     = {tx_reg[6:0], 1'b1};
                     bitcnt_next = bitcnt_reg + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (ev.rise) begin
                  mack_next = ~sda_in;
               end
               if (ev.fall) begin
                  if (mack_reg) begin
                     load_byte = 1'b1;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
            end
            ST_COMMIT: begin
               cidx_next = cidx_reg + 4'h1;
               if (cidx_reg == `EPR_ID_LAST) begin
                  vld_next       = 16'h0000;
                  lock_pend_next = 1'b0;
                  state_next     = ST_IDLE;
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
      if (load_byte) begin
         state_next  = ST_TX;
         tx_next     = rdata;
         oe_next     = ~rdata[7];
         bitcnt_next = 4'h1;
         if (is_id_reg) begin
            id_off_next = id_off_reg + 4'h1;
         end else begin
            cnt_next = cnt_reg + 11'h001;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_reg     <= ST_IDLE;
         phase_reg     <= PH_DEV;
         bitcnt_reg    <= 4'h0;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'hff;
         oe_reg        <= 1'b0;
         rd_reg        <= 1'b0;
         is_id_reg     <= 1'b0;
         sel_reg       <= 1'b0;
         mack_reg      <= 1'b0;
         lock_pend_reg <= 1'b0;
         blk_reg       <= 3'h0;
         cnt_reg       <= `EPR_CNT_RST;
         id_off_reg    <= 4'h0;
         cidx_reg      <= 4'h0;
         vld_reg       <= 16'h0000;
      end else begin
         state_reg     <= state_next;
         phase_reg     <= phase_next;
         bitcnt_reg    <= bitcnt_next;
         shift_reg     <= shift_next;
         tx_reg        <= tx_next;
         oe_reg        <= oe_next;
         rd_reg        <= rd_next;
         is_id_reg     <= is_id_next;
         sel_reg       <= sel_next;
         mack_reg      <= mack_next;
         lock_pend_reg <= lock_pend_next;
         blk_reg       <= blk_next;
         cnt_reg       <= cnt_next;
         id_off_reg    <= id_off_next;
         cidx_reg      <= cidx_next;
         vld_reg       <= vld_next;
      end
      stage_reg <= stage_next;
   end

   // Open-drain data: only ever pulls low
   assign sda_out       = 1'b0;
   assign sda_oe_out    = oe_reg;
   assign id_locked_out = locked;
   assign busy_out      = state_reg != ST_IDLE;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   AST_RESET_STANDBY: assert property (@(posedge mclk_in) disable iff (1'b0)
      sys_rst_in |=> state_reg == ST_IDLE && !oe_reg) else $error("not idle after reset");
   AST_IDLE_RELEASED: assert property (state_reg == ST_IDLE |-> !oe_reg)
      else $error("data driven while idle");
   AST_FIRST_BIT: assert property (load_byte |=> oe_reg == !$past(rdata[7]) &&
      state_reg == ST_TX) else $error("first data bit wrong");
   AST_CNT_STEP: assert property (load_byte && !is_id_reg && cnt_reg != `EPR_CNT_TOP
      |=> cnt_reg == $past(cnt_reg) + 11'h001) else $error("counter did not step");
   AST_CNT_WRAP: assert property (load_byte && !is_id_reg && cnt_reg == `EPR_CNT_TOP
      |=> cnt_reg == 11'h000) else $error("counter did not wrap");
   AST_LOCK_NACK: assert property (state_reg == ST_RX && ev.fall &&
      bitcnt_reg == `EPR_BITS_BYTE && phase_reg == PH_DATA && is_id_reg && locked
      |=> state_reg == ST_IDLE ##1 !oe_reg) else $error("locked page data acknowledged");
   AST_BAD_PREFIX: assert property (state_reg == ST_RX && ev.fall &&
      bitcnt_reg == `EPR_BITS_BYTE && phase_reg == PH_DEV && shift_reg[7:5] != 3'b101
      |=> state_reg == ST_IDLE && !oe_reg) else $error("foreign address answered");
   AST_START_DROPS: assert property (ev.start && state_reg != ST_COMMIT
      |=> vld_reg == 16'h0000 && !lock_pend_reg && phase_reg == PH_DEV)
      else $error("start kept pending write");
   AST_WRITE_DIR: assert property (state_reg == ST_ACK && ev.fall &&
      phase_reg == PH_DEV && !rd_reg |=> state_reg == ST_RX && phase_reg == PH_ADDR)
      else $error("write direction mishandled");
   AST_TX_HOLD: assert property (state_reg == ST_TX && !ev.fall && !ev.start && !ev.stop
      |=> $stable(oe_reg)) else $error("data moved outside clock low");

   COV_MAIN_READ: cover property (load_byte && !is_id_reg ##1 state_reg == ST_TX);
   COV_ID_READ: cover property (load_byte && is_id_reg);
   COV_WRAP: cover property (load_byte && cnt_reg == `EPR_CNT_TOP);
   COV_COMMIT: cover property (state_reg == ST_COMMIT && lock_pend_reg);

endmodule

// ==== include/epr_map.svh ====
// Constants of the two-wire EEPROM read and identification page block
`ifndef EPR_MAP_SVH
`define EPR_MAP_SVH

// -------------------------------------------------------------
// Device address byte, page select and lock bits
// -------------------------------------------------------------
`define EPR_DEV_MAIN      4'ha
`define EPR_DEV_ID        4'hb
`define EPR_RW_BIT        0
`define EPR_SEL_BIT       7
`define EPR_LOCK_BIT      1

// -------------------------------------------------------------
// Storage layout and reset values
// -------------------------------------------------------------
`define EPR_MEM_DEPTH     2064
`define EPR_ID_BASE       5'h10
`define EPR_ERASED        8'hff
`define EPR_CNT_RST       11'h000
`define EPR_CNT_TOP       11'h7ff
`define EPR_ID_LAST       4'hf
`define EPR_BITS_BYTE     4'h8

`endif

// ==== include/epr_pkg.sv ====
// Types of the two-wire EEPROM read and identification page block
package epr_pkg;

   // -------------------------------------------------------------
   // Protocol states, one-hot
   // -------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_RX     = 6'b000010,
      ST_ACK    = 6'b000100,
      ST_TX     = 6'b001000,
      ST_MACK   = 6'b010000,
      ST_COMMIT = 6'b100000
   } epr_state_t;

   // Which byte of a write is being received, one-hot
   typedef enum logic [2:0] {
      PH_DEV  = 3'b001,
      PH_ADDR = 3'b010,
      PH_DATA = 3'b100
   } epr_phase_t;

   // Bus events seen on the sampled lines
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } epr_bus_ev_t;

endpackage

// ==== rtl/epr_mem.sv ====
// Byte storage of main array and identification page, with lock flag
`include "epr_map.svh"

module epr_mem import epr_pkg::*; (
   input  wire logic        clk_in,
   input  wire logic        we_in,
   input  wire logic [11:0] waddr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        lock_set_in,
   input  wire logic [11:0] raddr_in,
   output logic      [7:0]  rdata_out,
   output logic             locked_out
);

   // -------------------------------------------------------------
   // Delivery state: all erased, page unlocked; not touched by reset
   // -------------------------------------------------------------
   // erased content
   logic [7:0] mem_reg [`EPR_MEM_DEPTH] = '{default: `EPR_ERASED};
   logic       lock_reg                 = 1'b0;

   // Registered read port, single write port, sticky lock
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_reg[waddr_in] <= wdata_in;
      end
      if (lock_set_in) begin
         lock_reg <= 1'b1;
      end
      rdata_out <= mem_reg[raddr_in];
   end

   assign locked_out = lock_reg;

endmodule

// ==== testbench/epr_bus_master.sv ====
// Bus master model: drives the serial clock and pulls the data line low
module epr_bus_master (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------
   // Idle bus: clock high, data released to the pull-up
   // -------------------------------------------------------------
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   // One clock half period, four system clocks, moved at falling edges
   task automatic half();
      repeat (4) @(negedge clk_in);
   endtask

   task automatic bus_start();
      sda_low_out = 1'b0;
      half();
      scl_out = 1'b1;
      half();
      sda_low_out = 1'b1;
      half();
      scl_out = 1'b0;
      half();
   endtask

   // stop: data rises while clock high
   task automatic bus_stop();
      sda_low_out = 1'b1;
      half();
      scl_out = 1'b1;
      half();
      sda_low_out = 1'b0;
      half();
   endtask

   // One bit: data set while clock low, sampled at end of high
   task automatic bit_xfer(input logic b, output logic seen);
      sda_low_out = ~b;
      half();
      scl_out = 1'b1;
      half();
      seen    = sda_in;
      scl_out = 1'b0;
      half();
   endtask

   // Byte out, most significant bit first, then the slave's answer
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(b[i], s);
      end
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask

   // nack: give_ack low leaves the slot high
   // count: caller never passes the page end
   task automatic recv_byte(input logic give_ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(~give_ack, s);
   endtask
endmodule

// ==== testbench/eeprom_read_and_id_page_tb_top.sv ====
// Self-checking bench of the two-wire EEPROM slave
module eeprom_read_and_id_page_tb_top import epr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] dev;
      logic       ack;
      logic [7:0] data;
   } epr_row_t;

   logic       mclk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       scl, sda_low, sda_line, sda_out, sda_oe_out, id_locked_out, busy_out;
   logic       ack;
   logic [7:0] d;
   int         miscompares = 0;
   int         n_checks = 0;
   epr_row_t   rows [6] = '{'{8'ha1, 1'b1, 8'hff}, '{8'haf, 1'b1, 8'hff},
                            '{8'hb1, 1'b1, 8'hff}, '{8'h21, 1'b0, 8'hff},
                            '{8'he1, 1'b0, 8'hff}, '{8'h91, 1'b0, 8'hff}};

   // -------------------------------------------------------------
   // Clock, wired-and data line, design and bus master
   // -------------------------------------------------------------
   always #12.5 mclk_in = ~mclk_in;
   assign sda_line = (sda_oe_out ? sda_out : 1'b1) & ~sda_low;

   epr_slave DUT (
      .mclk_in       (mclk_in),
      .sys_rst_in    (sys_rst_in),
      .scl_in        (scl),
      .sda_in        (sda_line),
      .sda_out       (sda_out),
      .sda_oe_out    (sda_oe_out),
      .id_locked_out (id_locked_out),
      .busy_out      (busy_out)
   );

   epr_bus_master bus_master (
      .clk_in      (mclk_in),
      .sda_in      (sda_line),
      .scl_out     (scl),
      .sda_low_out (sda_low)
   );

   // -------------------------------------------------------------
   // Checking and closing
   // -------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Byte out with its expected answer
   task automatic tx(input logic [7:0] b, input logic exp_ack);
      bus_master.send_byte(b, ack);
      check({7'h00, ack}, {7'h00, exp_ack});
   endtask

   // dummy write: address loaded with no data, then read direction
   task automatic load_addr(input logic [7:0] dev, input logic [7:0] addr);
      bus_master.bus_start();
      tx(dev, 1'b1);
      tx(addr, 1'b1);
      bus_master.bus_start();
      tx(dev | 8'h01, 1'b1);
   endtask

   // Let a staged commit finish after a Stop
   task automatic settle();
      repeat (40) @(negedge mclk_in);
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge mclk_in);
      miscompares++;
      $display("unexpected timeout at %0t", $time);
      complete_run();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (6) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      check({5'h00, sda_oe_out, busy_out, id_locked_out}, 8'h00);
      $display("reset test done");
      // Address prefixes, direction and erased contents
      for (int i = 0; i < 6; i++) begin
         bus_master.bus_start();
         tx(rows[i].dev, rows[i].ack);
         if (ack === 1'b1) begin
            bus_master.recv_byte(1'b0, d);
            check(d, rows[i].data);
            check({7'h00, sda_oe_out}, 8'h00);
         end
         bus_master.bus_stop();
         check({7'h00, busy_out}, 8'h00);
      end
      $display("table test done");
      // wrap: top block end rolls to zero
      load_addr(8'hae, 8'hfe);
      for (int i = 0; i < 4; i++) begin
         bus_master.recv_byte(i < 3, d);
         check(d, 8'hff);
      end
      bus_master.bus_stop();
      $display("wrap test done");
      // page write: three bytes from offset 3
      bus_master.bus_start();
      tx(8'hbe, 1'b1);
      tx(8'h73, 1'b1);
      tx(8'h5a, 1'b1);
      tx(8'ha5, 1'b1);
      tx(8'h3c, 1'b1);
      bus_master.bus_stop();
      settle();
      load_addr(8'hb0, 8'h03);
      bus_master.recv_byte(1'b1, d);
      check(d, 8'h5a);
      bus_master.recv_byte(1'b0, d);
      check(d, 8'ha5);
      bus_master.bus_stop();
      bus_master.bus_start();
      tx(8'hb1, 1'b1);
      bus_master.recv_byte(1'b0, d);
      check(d, 8'h3c);
      bus_master.bus_stop();
      $display("page test done");
      // probe: unlocked page acknowledges, Start discards
      bus_master.bus_start();
      tx(8'hb0, 1'b1);
      tx(8'h07, 1'b1);
      tx(8'h77, 1'b1);
      bus_master.bus_start();
      bus_master.bus_stop();
      settle();
      load_addr(8'hb0, 8'h07);
      bus_master.recv_byte(1'b0, d);
      check(d, 8'hff);
      bus_master.bus_stop();
      $display("probe test done");
      // lock: bit 1 clear leaves page open, bit 1 set locks
      bus_master.bus_start();
      tx(8'hb0, 1'b1);
      tx(8'h80, 1'b1);
      tx(8'hfd, 1'b1);
      bus_master.bus_stop();
      settle();
      check({7'h00, id_locked_out}, 8'h00);
      bus_master.bus_start();
      tx(8'hb0, 1'b1);
      tx(8'hff, 1'b1);
      tx(8'h02, 1'b1);
      bus_master.bus_stop();
      settle();
      check({7'h00, id_locked_out}, 8'h01);
      // locked: data byte refused and not stored
      bus_master.bus_start();
      tx(8'hb0, 1'b1);
      tx(8'h00, 1'b1);
      tx(8'h99, 1'b0);
      bus_master.bus_start();
      bus_master.bus_stop();
      settle();
      load_addr(8'hb0, 8'h00);
      bus_master.recv_byte(1'b0, d);
      check(d, 8'hff);
      bus_master.bus_stop();
      $display("lock test done");
      // mid-run reset while a read byte drives the line
      load_addr(8'hb0, 8'h03);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      check({5'h00, sda_oe_out, busy_out, id_locked_out}, 8'h01);
      bus_master.bus_start();
      tx(8'hb1, 1'b1);
      bus_master.recv_byte(1'b0, d);
      check(d, 8'hff);
      bus_master.bus_stop();
      $display("mid reset test done");
      complete_run();
   end
endmodule
